// ===== hdl/sad_decoder.sv
`timescale 1ns/1ns
`include "sad_map.svh"

// How it works
// RULE1 - an access to any unimplemented address raises a one-cycle illegal-address reset.
// RULE2 - reserved locations select a reserved target and raise no reset.
// RULE3 - addresses 0000 to 003F select the peripheral register file.
// RULE4 - addresses 0080 to 00FF select the 128-byte RAM, where the stack may sit anywhere.
// RULE5 - addresses 7800 to 7FEE select the 2031-byte user flash array.
// RULE6 - address 7FEF selects the single factory clock trim byte.
// RULE7 - F000 to F2EF and FEF0 to FEFF select the monitor ROM.
// RULE8 - in monitor mode the reset vector is fetched from the monitor ROM at FEFE.
// RULE9 - interrupt vector pairs sit at fixed addresses FFF2 to FFFC in rising priority.
// RULE10 - the reset vector is at FFFE and FFFF and beats every other vector.
// RULE11 - the high-page system registers decode at FE00, FE01, FE02, FE08, FE0C to FE0F.
// RULE12 - FFF0 selects flash block protection and a write to FFFF selects the watchdog control.
// RULE13 - interrupt entry pushes five context bytes and never the high index byte.
// RULE14 - a call pushes a two-byte return address; pushes decrement and pulls increment SP.
// RULE15 - region selection is combinational so a valid access sets exactly one target or the illegal flag.
module sad_decoder (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire sad_pkg::sad_bus_t    bus,
  input  wire logic                 mon_mode,
  input  wire logic                 vec_req,
  input  wire logic                 reset_fetch,
  input  wire sad_pkg::sad_irq_t    irq_pend,
  input  wire sad_pkg::sad_stk_req_t stk_req,
  input  wire sad_pkg::sad_ctx_t    ctx,
  output wire sad_pkg::sad_sel_t    sel,
  output logic                      illegal_rst,
  output logic                      vec_valid,
  output logic [15:0]               vec_addr,
  output logic [2:0]                vec_rank,
  output logic                      stk_we,
  output logic [15:0]               stk_addr,
  output logic [7:0]                stk_data,
  output wire logic                 stk_busy,
  output logic [15:0]               sp
);

  // ---------------- region decode ----------------
  wire logic [15:0] a = bus.addr;
  wire logic        hit_io;
  wire logic        hit_ram;
  wire logic        hit_flash;
  wire logic        hit_mon_lo;
  wire logic        hit_mon_hi;
  wire logic        hit_vec;
  wire logic        hit_rsvd_blk;

  sad_range #(.LO(`SAD_IO_LO), .HI(`SAD_IO_HI)) u_io (
    .addr (a),
    .hit  (hit_io)
  );
  sad_range #(.LO(`SAD_RAM_LO), .HI(`SAD_RAM_HI)) u_ram (
    .addr (a),
    .hit  (hit_ram)
  );
  sad_range #(.LO(`SAD_FLASH_LO), .HI(`SAD_FLASH_HI)) u_flash (
    .addr (a),
    .hit  (hit_flash)
  );
  sad_range #(.LO(`SAD_MON_LO), .HI(`SAD_MON_HI)) u_mon_lo (
    .addr (a),
    .hit  (hit_mon_lo)
  );
  sad_range #(.LO(`SAD_MONV_LO), .HI(`SAD_MONV_HI)) u_mon_hi (
    .addr (a),
    .hit  (hit_mon_hi)
  );
  sad_range #(.LO(`SAD_VEC_LO), .HI(`SAD_VEC_HI)) u_vec (
    .addr (a),
    .hit  (hit_vec)
  );
  sad_range #(.LO(`SAD_RSVD_LO), .HI(`SAD_RSVD_HI)) u_rsvd (
    .addr (a),
    .hit  (hit_rsvd_blk)
  );

  wire logic is_trim         = (a == `SAD_TRIM_ADDR);             // RULE6
  wire logic is_brk_stat     = (a == `SAD_BRK_STAT);              // RULE11
  wire logic is_rst_cause    = (a == `SAD_RST_CAUSE);             // RULE11
  wire logic is_brk_flag_ctl = (a == `SAD_BRK_FLAG_CTL);          // RULE11
  wire logic is_flash_ctl    = (a == `SAD_FLASH_CTL);             // RULE11
  wire logic is_brk_addr_h   = (a == `SAD_BRK_ADDR_H);            // RULE11
  wire logic is_brk_addr_l   = (a == `SAD_BRK_ADDR_L);            // RULE11
  wire logic is_brk_stat_ctl = (a == `SAD_BRK_STAT_CTL);          // RULE11
  wire logic is_lv_stat      = (a == `SAD_LV_STAT);               // RULE11
  wire logic is_flash_prot   = (a == `SAD_FLASH_PROT);            // RULE12
  wire logic is_wdog         = (a == `SAD_WDOG_CTL);              // RULE12
  // fff1 sits between protect byte and vectors; treated as reserved
  wire logic is_rsvd         = hit_rsvd_blk || (a == `SAD_RSVD_SINGLE) ||
                               (a == `SAD_RSVD_FFF1);             // RULE2

  wire logic is_sysreg = is_brk_stat | is_rst_cause | is_brk_flag_ctl | is_flash_ctl |
                         is_brk_addr_h | is_brk_addr_l | is_brk_stat_ctl | is_lv_stat;

  // anything left over is unimplemented
  wire logic any_hit = hit_io | hit_ram | hit_flash | is_trim | hit_mon_lo | hit_mon_hi |
                       is_sysreg | is_flash_prot | hit_vec | is_rsvd;

  // selects qualified by valid so an idle bus selects nothing
  wire logic v = bus.valid;

  assign sel.io           = v & hit_io;                           // RULE3 RULE15
  assign sel.ram          = v & hit_ram;                          // RULE4 RULE15
  assign sel.flash        = v & hit_flash;                        // RULE5 RULE15
  assign sel.trim         = v & is_trim;                          // RULE6
  assign sel.mon          = v & (hit_mon_lo | hit_mon_hi);        // RULE7 RULE8
  assign sel.brk_stat     = v & is_brk_stat;                      // RULE11
  assign sel.rst_cause    = v & is_rst_cause;                     // RULE11
  assign sel.brk_flag_ctl = v & is_brk_flag_ctl;                  // RULE11
  assign sel.flash_ctl    = v & is_flash_ctl;                     // RULE11
  assign sel.brk_addr_h   = v & is_brk_addr_h;                    // RULE11
  assign sel.brk_addr_l   = v & is_brk_addr_l;                    // RULE11
  assign sel.brk_stat_ctl = v & is_brk_stat_ctl;                  // RULE11
  assign sel.lv_stat      = v & is_lv_stat;                       // RULE11
  assign sel.flash_prot   = v & is_flash_prot;                    // RULE12
  assign sel.vec          = v & hit_vec & ~(is_wdog & bus.write); // RULE9 RULE10
  // ffff: a read returns the reset vector low byte, a write kicks the watchdog
  assign sel.wdog_ctl     = v & is_wdog & bus.write;              // RULE12
  assign sel.rsvd         = v & is_rsvd;                          // RULE2
  assign sel.illegal      = v & ~any_hit;                         // RULE1 RULE15

  // reset request is registered so it never feeds back into the same bus cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      illegal_rst <= 1'b0;
    end else begin
      illegal_rst <= sel.illegal;                                 // RULE1
    end
  end

  // ---------------- vector selection ----------------
  logic [15:0] vec_nxt;
  logic [2:0]  rank_nxt;
  wire logic   vec_take = vec_req | reset_fetch;
  wire logic [15:0] rst_vec = mon_mode ? `SAD_MON_RST_VEC : `SAD_VEC_RESET; // RULE8

  // highest priority first; rank 7 is reset, 1 is the clock generator
  always_comb begin
    vec_nxt  = `SAD_VEC_RESET;
    rank_nxt = 3'h0;
    if (reset_fetch) begin
      vec_nxt  = rst_vec;                                         // RULE10
      rank_nxt = 3'h7;
    end else if (irq_pend.software_interrupt) begin
      vec_nxt  = `SAD_VEC_SWI;                                    // RULE9
      rank_nxt = 3'h6;
    end else if (irq_pend.ext_kbd) begin
      vec_nxt  = `SAD_VEC_EXTKBD;                                 // RULE9
      rank_nxt = 3'h5;
    end else if (irq_pend.tch0) begin
      vec_nxt  = `SAD_VEC_TCH0;                                   // RULE9
      rank_nxt = 3'h4;
    end else if (irq_pend.tch1) begin
      vec_nxt  = `SAD_VEC_TCH1;                                   // RULE9
      rank_nxt = 3'h3;
    end else if (irq_pend.tovf) begin
      vec_nxt  = `SAD_VEC_TOVF;                                   // RULE9
      rank_nxt = 3'h2;
    end else if (irq_pend.clkgen) begin
      vec_nxt  = `SAD_VEC_CLKGEN;                                 // RULE9
      rank_nxt = 3'h1;
    end
  end

  // a request with nothing pending gives no answer
  wire logic vec_hit = reset_fetch | (|irq_pend);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_valid <= 1'b0;
      vec_addr  <= `SAD_VEC_RESET;
      vec_rank  <= 3'h0;
    end else begin
      vec_valid <= vec_take & vec_hit;
      if (vec_take & vec_hit) begin
        vec_addr <= vec_nxt;
        vec_rank <= rank_nxt;
      end
    end
  end

  // ---------------- stack sequencer ----------------
  sad_pkg::sad_stk_state_t st_r;
  sad_pkg::sad_stk_state_t st_nxt;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  logic        is_int_r;
  logic        is_int_nxt;
  logic [15:0] sp_r;
  logic [15:0] sp_nxt;
  sad_pkg::sad_ctx_t ctx_r;
  logic [7:0]  byte_sel;
  wire logic   start_int  = stk_req.int_entry;
  wire logic   start_call = stk_req.call & ~stk_req.int_entry;
  wire logic   pushing    = (st_r == sad_pkg::SAD_STK_PUSH);
  wire logic [2:0] frame  = is_int_r ? `SAD_INT_FRAME : `SAD_CALL_FRAME; // RULE13 RULE14
  wire logic   last_push  = pushing && (cnt_r == frame - 3'h1);

  assign stk_busy = pushing;

  // push order: pc low, pc high, x, a, ccr; high index byte never stacked
  always_comb begin
    case (cnt_r)
      3'h0:    byte_sel = ctx_r.pc[7:0];
      3'h1:    byte_sel = ctx_r.pc[15:8];
      3'h2:    byte_sel = ctx_r.x;                                // RULE13
      3'h3:    byte_sel = ctx_r.a;                                // RULE13
      3'h4:    byte_sel = ctx_r.ccr;                              // RULE13
      default: byte_sel = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    is_int_nxt = is_int_r;
    sp_nxt     = sp_r;
    case (st_r)
      sad_pkg::SAD_STK_IDLE: begin
        cnt_nxt = 3'h0;
        if (stk_req.sp_load) begin
          sp_nxt = stk_req.sp_value;
        end else if (start_int | start_call) begin
          st_nxt     = sad_pkg::SAD_STK_PUSH;
          is_int_nxt = start_int;
        end else if (stk_req.pull) begin
          sp_nxt = sp_r + 16'h0001;                               // RULE14
        end
      end
      sad_pkg::SAD_STK_PUSH: begin
        sp_nxt  = sp_r - 16'h0001;                                // RULE14
        cnt_nxt = cnt_r + 3'h1;
        if (last_push) begin
          st_nxt  = sad_pkg::SAD_STK_IDLE;
          cnt_nxt = 3'h0;
        end
      end
      default: begin
        st_nxt  = sad_pkg::SAD_STK_IDLE;
        cnt_nxt = 3'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= sad_pkg::SAD_STK_IDLE;
      cnt_r    <= 3'h0;
      is_int_r <= 1'b0;
      sp_r     <= `SAD_SP_RESET;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      is_int_r <= is_int_nxt;
      sp_r     <= sp_nxt;
    end
  end

  // context captured at the request so a core change mid-frame cannot tear it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctx_r <= '0;
    end else if (st_r == sad_pkg::SAD_STK_IDLE && (start_int | start_call)) begin
      ctx_r <= ctx;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stk_we   <= 1'b0;
      stk_addr <= `SAD_SP_RESET;
      stk_data <= 8'h00;
    end else begin
      stk_we   <= pushing;                                        // RULE13 RULE14
      stk_addr <= sp_r;
      stk_data <= byte_sel;
    end
  end

  assign sp = sp_r;

endmodule : sad_decoder

// ===== hdl/sad_map.svh
`ifndef SAD_MAP_SVH
`define SAD_MAP_SVH

// low page peripheral registers
`define SAD_IO_LO          16'h0000
`define SAD_IO_HI          16'h003F
// read/write memory, stack lives here
`define SAD_RAM_LO         16'h0080
`define SAD_RAM_HI         16'h00FF
`define SAD_RAM_BYTES      128
// user program array and trim byte
`define SAD_FLASH_LO       16'h7800
`define SAD_FLASH_HI       16'h7FEE
`define SAD_FLASH_BYTES    2031
`define SAD_TRIM_ADDR      16'h7FEF
// monitor rom, two windows
`define SAD_MON_LO         16'hF000
`define SAD_MON_HI         16'hF2EF
`define SAD_MONV_LO        16'hFEF0
`define SAD_MONV_HI        16'hFEFF
`define SAD_MON_RST_VEC    16'hFEFE
// high page system registers
`define SAD_BRK_STAT       16'hFE00
`define SAD_RST_CAUSE      16'hFE01
`define SAD_BRK_FLAG_CTL   16'hFE02
`define SAD_RSVD_LO        16'hFE03
`define SAD_RSVD_HI        16'hFE06
`define SAD_FLASH_CTL      16'hFE08
`define SAD_RSVD_SINGLE    16'hFE09
`define SAD_BRK_ADDR_H     16'hFE0C
`define SAD_BRK_ADDR_L     16'hFE0D
`define SAD_BRK_STAT_CTL   16'hFE0E
`define SAD_LV_STAT        16'hFE0F
`define SAD_FLASH_PROT     16'hFFF0
`define SAD_RSVD_FFF1      16'hFFF1
// vector table, high byte at the even address
`define SAD_VEC_LO         16'hFFF2
`define SAD_VEC_HI         16'hFFFF
`define SAD_VEC_CLKGEN     16'hFFF2
`define SAD_VEC_TOVF       16'hFFF4
`define SAD_VEC_TCH1       16'hFFF6
`define SAD_VEC_TCH0       16'hFFF8
`define SAD_VEC_EXTKBD     16'hFFFA
`define SAD_VEC_SWI        16'hFFFC
`define SAD_VEC_RESET      16'hFFFE
`define SAD_WDOG_CTL       16'hFFFF
// stack frame sizes
`define SAD_INT_FRAME      3'h5
`define SAD_CALL_FRAME     3'h2
`define SAD_SP_RESET       16'h00FF

`endif

// ===== hdl/sad_pkg.sv
package sad_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
  } sad_bus_t;

  typedef struct packed {
    logic io;
    logic ram;
    logic flash;
    logic trim;
    logic mon;
    logic brk_stat;
    logic rst_cause;
    logic brk_flag_ctl;
    logic flash_ctl;
    logic brk_addr_h;
    logic brk_addr_l;
    logic brk_stat_ctl;
    logic lv_stat;
    logic flash_prot;
    logic vec;
    logic wdog_ctl;
    logic rsvd;
    logic illegal;
  } sad_sel_t;

  typedef struct packed {
    logic software_interrupt;
    logic ext_kbd;
    logic tch0;
    logic tch1;
    logic tovf;
    logic clkgen;
  } sad_irq_t;

  typedef struct packed {
    logic        int_entry;
    logic        call;
    logic        pull;
    logic        sp_load;
    logic [15:0] sp_value;
  } sad_stk_req_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  ccr;
  } sad_ctx_t;

  typedef enum logic [1:0] {
    SAD_STK_IDLE = 2'b01,
    SAD_STK_PUSH = 2'b10
  } sad_stk_state_t;

endpackage : sad_pkg

// ===== hdl/sad_range.sv
`timescale 1ns/1ns
module sad_range #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hFFFF
) (
  input  wire logic [15:0] addr,
  output wire logic        hit
);
  assign hit = (addr >= LO) && (addr <= HI);
endmodule : sad_range

// ===== test/sad_cpu_model.sv
`timescale 1ns/1ns
module sad_cpu_model (
  input wire logic              sys_clk,
  output sad_pkg::sad_bus_t     bus,
  output logic                  mon_mode,
  output logic                  vec_req,
  output logic                  reset_fetch,
  output sad_pkg::sad_irq_t     irq_pend,
  output sad_pkg::sad_stk_req_t stk_req,
  output sad_pkg::sad_ctx_t     ctx
);
  initial begin
    bus = '0;
    mon_mode = 1'b0;
    vec_req = 1'b0;
    reset_fetch = 1'b0;
    irq_pend = '0;
    stk_req = '0;
    ctx = '0;
  end

  task automatic access(input logic [15:0] a, input logic w);
    @(posedge sys_clk);
    bus <= '{valid: 1'b1, write: w, addr: a};
  endtask : access

  // released bus shows no stale address
  task automatic release_bus;
    @(posedge sys_clk);
    bus <= '{valid: 1'b0, write: ~bus.write, addr: ~bus.addr};
  endtask : release_bus

  task automatic vector(input logic rf, input logic mm, input sad_pkg::sad_irq_t p);
    @(posedge sys_clk);
    vec_req <= ~rf;
    reset_fetch <= rf;
    mon_mode <= mm;
    irq_pend <= p;
    @(posedge sys_clk);
    vec_req <= 1'b0;
    reset_fetch <= 1'b0;
    irq_pend <= '0;
  endtask : vector

  // kind bits: interrupt entry, call, pull, load
  task automatic stack(input logic [3:0] kind, input logic [15:0] v, input sad_pkg::sad_ctx_t c);
    @(posedge sys_clk);
    stk_req <= {kind, v};
    ctx <= c;
    @(posedge sys_clk);
    stk_req <= '0;
  endtask : stack
endmodule : sad_cpu_model

// ===== test/sad_decoder_chk.sv
`timescale 1ns/1ns
module sad_decoder_chk (
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire sad_pkg::sad_bus_t     bus,
  input wire logic                  mon_mode,
  input wire logic                  vec_req,
  input wire logic                  reset_fetch,
  input wire sad_pkg::sad_irq_t     irq_pend,
  input wire sad_pkg::sad_stk_req_t stk_req,
  input wire sad_pkg::sad_ctx_t     ctx,
  input wire sad_pkg::sad_sel_t     sel,
  input wire logic                  illegal_rst,
  input wire logic                  vec_valid,
  input wire logic [15:0]           vec_addr,
  input wire logic [2:0]            vec_rank,
  input wire logic                  stk_we,
  input wire logic [15:0]           stk_addr,
  input wire logic [7:0]            stk_data,
  input wire logic                  stk_busy,
  input wire logic [15:0]           sp
);
  wire logic [2:0]  irq_rank;
  wire logic [2:0]  exp_rank;
  wire logic [15:0] exp_vec;
  wire logic        push_ok;
  assign irq_rank = irq_pend.software_interrupt ? 3'h6 : irq_pend.ext_kbd ? 3'h5 : irq_pend.tch0 ? 3'h4 :
                    irq_pend.tch1 ? 3'h3 : irq_pend.tovf ? 3'h2 : {2'h0, irq_pend.clkgen};
  assign exp_rank = reset_fetch ? 3'h7 : irq_rank;
  // monitor mode moves only the reset vector
  assign exp_vec  = (mon_mode && reset_fetch) ? 16'hFEFE : 16'hFFF0 + {12'h0, exp_rank, 1'b0};
  assign push_ok  = !stk_busy && !stk_req.sp_load;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sel_onehot_a: assert property (bus.valid |-> $onehot(sel))
    else $error("select not one-hot");
  sel_idle_a: assert property (!bus.valid |-> sel == '0)
    else $error("select active without a cycle");
  illegal_map_a: assert property (bus.valid && (bus.addr inside {[16'h0040:16'h007F],
    [16'h0100:16'h77FF], [16'h7FF0:16'hEFFF], [16'hF2F0:16'hFDFF]}) |-> sel.illegal)
    else $error("unimplemented address not flagged");
  illegal_pulse_a: assert property (sel.illegal |=> illegal_rst)
    else $error("no illegal-address reset");
  reserved_quiet_a: assert property (bus.valid && (bus.addr inside
    {[16'hFE03:16'hFE06], 16'hFE09}) |-> sel.rsvd ##1 !illegal_rst)
    else $error("reserved access misdecoded");
  low_page_a: assert property (bus.valid && bus.addr <= 16'h003F |-> sel.io)
    else $error("io page misdecoded");
  ram_page_a: assert property (bus.valid && bus.addr inside {[16'h0080:16'h00FF]}
    |-> sel.ram)
    else $error("ram misdecoded");
  flash_trim_a: assert property (bus.valid && bus.addr inside {[16'h7800:16'h7FEF]}
    |-> ((bus.addr == 16'h7FEF) ? sel.trim : sel.flash))
    else $error("flash or trim misdecoded");
  vec_answer_a: assert property ((reset_fetch || (vec_req && |irq_pend)) |=>
    vec_valid && vec_rank == $past(exp_rank) && vec_addr == $past(exp_vec))
    else $error("wrong vector answer");
  int_frame_a: assert property (stk_req.int_entry && push_ok |=> ##1 stk_we [*5] ##1 !stk_we)
    else $error("interrupt frame not five bytes");
  call_frame_a: assert property (stk_req.call && !stk_req.int_entry && push_ok
    |=> ##1 stk_we [*2] ##1 !stk_we)
    else $error("call frame not two bytes");
  push_addr_a: assert property (stk_we |-> stk_addr == sp + 16'h1)
    else $error("push address off stack pointer");

  cover property (illegal_rst);
  cover property (vec_valid && vec_rank == 3'h7);
  cover property (stk_we [*5]);
endmodule : sad_decoder_chk

bind sad_decoder sad_decoder_chk chk_u (.sys_clk, .rst_n, .bus, .mon_mode, .vec_req,
  .reset_fetch, .irq_pend, .stk_req, .ctx, .sel, .illegal_rst, .vec_valid, .vec_addr,
  .vec_rank, .stk_we, .stk_addr, .stk_data, .stk_busy, .sp);

// ===== test/system_address_decoder_tb.sv
`timescale 1ns/1ns
module system_address_decoder_tb;
  typedef struct { logic [15:0] a; logic w; int k; } sad_map_t;
  logic                  sys_clk;
  logic                  rst_n;
  sad_pkg::sad_bus_t     bus;
  logic                  mon_mode;
  logic                  vec_req;
  logic                  reset_fetch;
  sad_pkg::sad_irq_t     irq_pend;
  sad_pkg::sad_stk_req_t stk_req;
  sad_pkg::sad_ctx_t     ctx;
  sad_pkg::sad_sel_t     sel;
  logic                  illegal_rst;
  logic                  vec_valid;
  logic [15:0]           vec_addr;
  logic [2:0]            vec_rank;
  logic                  stk_we;
  logic [15:0]           stk_addr;
  logic [7:0]            stk_data;
  logic                  stk_busy;
  logic [15:0]           sp;
  int                    n_errors;
  int                    tests_run;

  sad_cpu_model cpu_u (.sys_clk, .bus, .mon_mode, .vec_req, .reset_fetch, .irq_pend,
    .stk_req, .ctx);
  sad_decoder dut_u (.sys_clk, .rst_n, .bus, .mon_mode, .vec_req, .reset_fetch, .irq_pend,
    .stk_req, .ctx, .sel, .illegal_rst, .vec_valid, .vec_addr, .vec_rank, .stk_we,
    .stk_addr, .stk_data, .stk_busy, .sp);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk_sel(input sad_pkg::sad_sel_t got, input sad_pkg::sad_sel_t exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: select %h, expected %h", $time, got, exp);
    end
  endtask : chk_sel

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // one address per cycle, so the reset pulse of one lands beside the next decode
  task automatic map_scan;
    sad_map_t t [$] = '{'{16'h0000,0,17}, '{16'h003F,0,17}, '{16'h0040,1,0}, '{16'h007F,0,0},
      '{16'h0080,1,16}, '{16'h00FF,0,16}, '{16'h0100,0,0}, '{16'h77FF,0,0}, '{16'h7800,0,15},
      '{16'h7FEE,0,15}, '{16'h7FEF,0,14}, '{16'h7FF0,0,0}, '{16'hEFFF,0,0}, '{16'hF000,0,13},
      '{16'hF2EF,0,13}, '{16'hF2F0,0,0}, '{16'hFDFF,0,0}, '{16'hFE00,0,12}, '{16'hFE01,0,11},
      '{16'hFE02,0,10}, '{16'hFE03,0,1}, '{16'hFE06,1,1}, '{16'hFE07,0,0}, '{16'hFE08,0,9},
      '{16'hFE09,0,1}, '{16'hFE0A,0,0}, '{16'hFE0C,0,8}, '{16'hFE0D,0,7}, '{16'hFE0E,0,6},
      '{16'hFE0F,0,5}, '{16'hFEF0,0,13}, '{16'hFEFF,0,13}, '{16'hFFF0,0,4}, '{16'hFFF2,0,3},
      '{16'hFFFC,0,3}, '{16'hFFFE,0,3}, '{16'hFFFF,0,3}, '{16'hFFFF,1,2}};
    logic prev;
    prev = 1'b0;
    foreach (t[i]) begin
      cpu_u.access(t[i].a, t[i].w);
      @(negedge sys_clk);
      chk_sel(sel, 18'h1 << t[i].k);
      chk_val({15'h0, illegal_rst}, {15'h0, prev});
      prev = (t[i].k == 0);
    end
    cpu_u.release_bus();
    @(negedge sys_clk);
    chk_sel(sel, '0);
    chk_val({15'h0, illegal_rst}, {15'h0, prev});
  endtask : map_scan

  task automatic vec_scan;
    for (int r = 1; r <= 6; r++) begin
      cpu_u.vector(1'b0, 1'b0, sad_pkg::sad_irq_t'((6'h1 << r) - 6'h1));
      @(negedge sys_clk);
      chk_val({15'h0, vec_valid}, 16'h1);
      chk_val(vec_addr, 16'hFFF0 + 16'(2 * r));
      chk_val({13'h0, vec_rank}, 16'(r));
    end
    for (int m = 0; m < 2; m++) begin
      cpu_u.vector(1'b1, m[0], '1);
      @(negedge sys_clk);
      chk_val(vec_addr, m[0] ? 16'hFEFE : 16'hFFFE);
      chk_val({13'h0, vec_rank}, 16'h7);
    end
    cpu_u.vector(1'b0, 1'b0, '0);
    @(negedge sys_clk);
    chk_val({15'h0, vec_valid}, 16'h0);
  endtask : vec_scan

  task automatic stk_run(input logic [3:0] kind, input int n, input sad_pkg::sad_ctx_t c);
    logic [7:0]  exp [5];
    logic [15:0] s0;
    int          got;
    exp = '{c.pc[7:0], c.pc[15:8], c.x, c.a, c.ccr};
    s0 = sp;
    got = 0;
    cpu_u.stack(kind, 16'h0000, c);
    @(negedge sys_clk);
    chk_val({15'h0, stk_busy}, 16'h1);
    repeat (8) begin
      @(negedge sys_clk);
      if (stk_we === 1'b1) begin
        chk_val(stk_addr, s0 - 16'(got));
        chk_val({8'h0, stk_data}, {8'h0, exp[got]});
        got++;
      end
    end
    chk_val(16'(got), 16'(n));
    chk_val(sp, s0 - 16'(n));
    chk_val({15'h0, stk_busy}, 16'h0);
  endtask : stk_run

  task automatic stack_scan;
    cpu_u.stack(4'h1, 16'h00C0, '0);
    @(negedge sys_clk);
    chk_val(sp, 16'h00C0);
    stk_run(4'h4, 2, '{16'h1234, 8'h56, 8'h78, 8'h9A});
    stk_run(4'hC, 5, '{16'hA1B2, 8'hC3, 8'hD4, 8'hE5});
    cpu_u.stack(4'h2, 16'h0000, '0);
    @(negedge sys_clk);
    chk_val(sp, 16'h00BA);
  endtask : stack_scan

  initial begin
    rst_n = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk_val(sp, 16'h00FF);
    chk_val(vec_addr, 16'hFFFE);
    map_scan();
    vec_scan();
    stack_scan();
    summarize();
  end

  // whole run is about a hundred cycles
  initial begin
    #20000;
    n_errors++;
    $display("Error %0t: timeout", $time);
    summarize();
  end
endmodule : system_address_decoder_tb
